/* shared/hdr_codec_pkg.sv */
// constants, types and field layout shared by the radio header codec
package hdr_codec_pkg;
  // character codes used when composing callsign fields
  localparam logic [7:0] SPACE_CHAR = 8'h20;
  localparam logic [7:0] CHAR_A = 8'h41;
  localparam logic [7:0] CHAR_F = 8'h46;
  localparam logic [7:0] CHAR_G = 8'h47;
  localparam logic [7:0] CHAR_S = 8'h53;
  localparam logic [7:0] SLASH_CHAR = 8'h2F;
  // general-call text, first character in the low byte
  localparam logic [47:0] GENERAL_CALL = 48'h514351435143;
  localparam int BASE_CHARS = 6;
  localparam int FIELD_CHARS = 8;
  localparam int OWN2_CHARS = 4;
  // bit positions of the fields in the serial header, byte 0 first
  localparam int DEST_POS = 24;
  localparam int DEP_POS = 88;
  localparam int COMP_POS = 152;
  localparam int OWN1_POS = 216;
  localparam int OWN2_POS = 280;
  localparam int HDR_BITS = 312;
  localparam int CRC_BITS = 16;
  localparam int PROT_BITS = 328;
  localparam int ENC_BITS = 330;
  localparam int CODED_BITS = 660;
  // interleaver matrix shape
  localparam logic [4:0] IL_LAST_ROW = 5'h17;
  localparam logic [4:0] IL_LONG_ROWS = 5'h0C;
  localparam logic [4:0] IL_LONG_LAST_COL = 5'h1B;
  localparam logic [4:0] IL_SHORT_LAST_COL = 5'h1A;
  localparam logic [9:0] IL_DEPTH = 10'h018;
  // scrambler, convolutional and checksum parameters
  localparam logic [6:0] SCR_INIT = 7'h7F;
  localparam logic [2:0] CONV_G1 = 3'h7;
  localparam logic [2:0] CONV_G2 = 3'h5;
  localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [10:0] PM_BAD = 11'h200;
  // bit timing
  localparam int CLK_HZ = 20000000;
  localparam int BIT_RATE_HZ = 4800;
  localparam int BIT_DIV = CLK_HZ / BIT_RATE_HZ;

  typedef enum logic [1:0] {
    CM_STATION = 2'b00,
    CM_CQ = 2'b01,
    CM_CQ_ZONE = 2'b10,
    CM_SERVER = 2'b11
  } comp_mode_e;

  typedef struct packed {
    logic [47:0] chars;
    logic [2:0] len;
  } call_s;

  typedef struct packed {
    logic [23:0] flags;
    call_s own_rptr;
    call_s comp_rptr;
    call_s gw_rptr;
    call_s comp_call;
    call_s own_call;
    logic [31:0] own2;
    logic [2:0] own2_len;
    logic zone_to_zone;
    logic [1:0] dest_site;
    logic [1:0] dep_site;
    comp_mode_e comp_mode;
    logic [2:0] comp_radio;
    logic [2:0] own_radio;
  } hdr_req_s;
endpackage

/* core/radio_header_fec_codec.sv */
// radio header composer, scrambler, convolutional coder, interleaver and receive decoder
`timescale 1ns/1ps
`default_nettype none
module radio_header_fec_codec #(
  parameter int BIT_DIV = hdr_codec_pkg::BIT_DIV
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // header request
  input wire logic tx_start,
  input wire hdr_codec_pkg::hdr_req_s tx_req,
  output logic tx_busy,
  // transmit bit stream
  output logic tx_bit,
  output logic tx_bit_valid,
  // payload frames after the header
  output logic pay_take,
  input wire logic pay_bit,
  input wire logic pay_scramble,
  input wire logic pay_end,
  // receive header stream
  input wire logic rx_start,
  input wire logic rx_valid,
  input wire logic rx_bit,
  output logic rx_done,
  output logic rx_crc_ok,
  output logic [327:0] rx_header,
  output logic [63:0] rx_station_id
);

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_ENC = 2'b01,
    TX_SEND = 2'b10,
    TX_PAY = 2'b11
  } tx_state_e;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_FILL = 3'b001,
    RX_ACS = 3'b010,
    RX_TB = 3'b011,
    RX_CHK = 3'b100
  } rx_state_e;

  function automatic logic [63:0] fill_field(input logic [47:0] base, input logic [2:0] len,
                                             input logic [7:0] last);
    logic [63:0] f;
    f = '0;
    for (int i = 0; i < hdr_codec_pkg::FIELD_CHARS; i++) begin
      if (i == hdr_codec_pkg::FIELD_CHARS - 1) begin
        f[8*i+:8] = last;
      end else if (i < hdr_codec_pkg::BASE_CHARS && i < int'(len)) begin
        f[8*i+:8] = base[8*i+:8];
      end else begin
        f[8*i+:8] = hdr_codec_pkg::SPACE_CHAR;
      end
    end
    return f;
  endfunction

  function automatic logic [7:0] radio_char(input logic [2:0] r);
    logic [7:0] c;
    c = hdr_codec_pkg::CHAR_A + {5'h00, r} - 8'h01;
    if (r == 3'h0) begin
      c = hdr_codec_pkg::SPACE_CHAR;
    end else if (c > hdr_codec_pkg::CHAR_F) begin
      c = hdr_codec_pkg::CHAR_F;
    end
    return c;
  endfunction

  function automatic logic [1:0] conv_out(input logic u, input logic [1:0] st);
    return {^({u, st} & hdr_codec_pkg::CONV_G2), ^({u, st} & hdr_codec_pkg::CONV_G1)};
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    return (c >> 1) ^ ((c[0] ^ b) ? hdr_codec_pkg::CRC_POLY_REFL : 16'h0000);
  endfunction

  // field composition
  wire logic [7:0] dest_site_c = hdr_codec_pkg::CHAR_A + {6'h00, tx_req.dest_site};
  wire logic [7:0] dep_site_c = hdr_codec_pkg::CHAR_A + {6'h00, tx_req.dep_site};
  wire logic [63:0] dest_f = tx_req.zone_to_zone ?
      fill_field(tx_req.gw_rptr.chars, tx_req.gw_rptr.len, hdr_codec_pkg::CHAR_G) :
      fill_field(tx_req.comp_rptr.chars, tx_req.comp_rptr.len, dest_site_c);
  wire logic [63:0] dep_f = fill_field(tx_req.own_rptr.chars, tx_req.own_rptr.len, dep_site_c);
  wire logic [63:0] comp_st_f = fill_field(tx_req.comp_call.chars, tx_req.comp_call.len,
                                           radio_char(tx_req.comp_radio));
  wire logic [63:0] comp_rp_f = fill_field(tx_req.comp_rptr.chars, tx_req.comp_rptr.len,
                                           hdr_codec_pkg::SPACE_CHAR);
  wire logic [63:0] comp_srv_f = fill_field(tx_req.comp_rptr.chars, tx_req.comp_rptr.len,
                                            hdr_codec_pkg::CHAR_S);
  logic [63:0] comp_f;
  logic [31:0] own2_f;
  wire logic [63:0] own1_f = fill_field(tx_req.own_call.chars, tx_req.own_call.len,
                                        radio_char(tx_req.own_radio));

  always_comb begin
    unique case (tx_req.comp_mode)
      hdr_codec_pkg::CM_STATION: comp_f = comp_st_f;
      hdr_codec_pkg::CM_CQ: comp_f = {{2{hdr_codec_pkg::SPACE_CHAR}}, hdr_codec_pkg::GENERAL_CALL};
      hdr_codec_pkg::CM_CQ_ZONE: comp_f = {dest_site_c, comp_rp_f[47:0], hdr_codec_pkg::SLASH_CHAR};
      hdr_codec_pkg::CM_SERVER: comp_f = comp_srv_f;
    endcase
  end

  always_comb begin
    own2_f = '0;
    for (int i = 0; i < hdr_codec_pkg::OWN2_CHARS; i++) begin
      own2_f[8*i+:8] = (i < int'(tx_req.own2_len)) ? tx_req.own2[8*i+:8] :
                       hdr_codec_pkg::SPACE_CHAR;
    end
  end

  wire logic [311:0] hdr_w = {own2_f, own1_f, comp_f, dep_f, dest_f, tx_req.flags};

  // bit-rate divider
  logic [12:0] div_q;
  wire logic bit_en = (div_q == 13'(BIT_DIV - 1));

  always_ff @(posedge ref_clk) begin
    if (!rst_n || bit_en) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 13'h0001;
    end
  end

  // transmit path
  tx_state_e tx_st_q;
  logic [311:0] tx_hdr_q;
  logic [15:0] tx_crc_q;
  logic [8:0] tx_t_q;
  logic [1:0] enc_q;
  logic [6:0] tx_scr_q;
  logic [4:0] tx_row_q, tx_col_q;
  logic tx_bit_q, tx_valid_q;
  logic coded_mem [hdr_codec_pkg::CODED_BITS];

  wire logic tx_seq = tx_scr_q[6] ^ tx_scr_q[3];
  // LSB-first header, checksum, then zero flush
  wire logic enc_u = (tx_t_q < 9'(hdr_codec_pkg::HDR_BITS)) ? tx_hdr_q[tx_t_q] :
                     (tx_t_q < 9'(hdr_codec_pkg::PROT_BITS)) ?
                     ~tx_crc_q[4'(tx_t_q - 9'(hdr_codec_pkg::HDR_BITS))] : 1'b0;
  // two coded bits per input bit
  wire logic [1:0] enc_c = conv_out(enc_u, enc_q);
  wire logic [9:0] tx_k = 10'(tx_col_q) * hdr_codec_pkg::IL_DEPTH + 10'(tx_row_q);
  wire logic tx_row_end = tx_col_q == ((tx_row_q < hdr_codec_pkg::IL_LONG_ROWS) ?
                          hdr_codec_pkg::IL_LONG_LAST_COL : hdr_codec_pkg::IL_SHORT_LAST_COL);
  wire logic tx_last = tx_row_end && (tx_row_q == hdr_codec_pkg::IL_LAST_ROW);
  wire logic tx_send_en = (tx_st_q == TX_SEND) && bit_en;
  assign pay_take = (tx_st_q == TX_PAY) && bit_en;

  always_ff @(posedge ref_clk) begin
    if (tx_st_q == TX_ENC) begin
      coded_mem[{tx_t_q, 1'b0}] <= enc_c[0];
      coded_mem[{tx_t_q, 1'b1}] <= enc_c[1];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_st_q <= TX_IDLE;
      tx_hdr_q <= '0;
      tx_crc_q <= hdr_codec_pkg::CRC_INIT;
      tx_t_q <= '0;
      enc_q <= '0;
      tx_scr_q <= hdr_codec_pkg::SCR_INIT;
      tx_row_q <= '0;
      tx_col_q <= '0;
      tx_bit_q <= 1'b0;
      tx_valid_q <= 1'b0;
    end else begin
      tx_valid_q <= tx_send_en || pay_take;
      unique case (tx_st_q)
        TX_IDLE: begin
          if (tx_start) begin
            tx_hdr_q <= hdr_w;
            enc_q <= '0;
            tx_scr_q <= hdr_codec_pkg::SCR_INIT;
            tx_crc_q <= hdr_codec_pkg::CRC_INIT;
            tx_t_q <= '0;
            tx_st_q <= TX_ENC;
          end
        end
        TX_ENC: begin
          if (tx_t_q < 9'(hdr_codec_pkg::HDR_BITS)) begin
            tx_crc_q <= crc_step(tx_crc_q, enc_u);
          end
          enc_q <= {enc_u, enc_q[1]};
          tx_t_q <= tx_t_q + 9'h001;
          if (tx_t_q == 9'(hdr_codec_pkg::ENC_BITS - 1)) begin
            tx_row_q <= '0;
            tx_col_q <= '0;
            tx_st_q <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (bit_en) begin
            tx_bit_q <= coded_mem[tx_k] ^ tx_seq;
            tx_scr_q <= {tx_scr_q[5:0], tx_seq};
            tx_col_q <= tx_row_end ? 5'h00 : tx_col_q + 5'h01;
            tx_row_q <= tx_row_end ? tx_row_q + 5'h01 : tx_row_q;
            if (tx_last) begin
              tx_st_q <= TX_PAY;
            end
          end
        end
        TX_PAY: begin
          if (bit_en) begin
            // sync and terminator frames sent clear
            tx_bit_q <= pay_bit ^ (pay_scramble & tx_seq);
            if (pay_scramble) begin
              tx_scr_q <= {tx_scr_q[5:0], tx_seq};
            end
            if (pay_end) begin
              tx_st_q <= TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign tx_busy = (tx_st_q != TX_IDLE);
  assign tx_bit = tx_bit_q;
  assign tx_bit_valid = tx_valid_q;

  // receive path
  rx_state_e rx_st_q;
  logic [6:0] rx_scr_q;
  logic [4:0] rx_row_q, rx_col_q;
  logic [8:0] rx_t_q;
  logic [1:0] tb_s_q;
  logic [15:0] rx_crc_q;
  logic [327:0] rx_hdr_q;
  logic rx_done_q, rx_ok_q;
  logic [327:0] rx_out_q;
  logic [10:0] pm_q [4];
  logic [10:0] pm_d [4];
  logic [3:0] dec;
  logic rx_mem [hdr_codec_pkg::CODED_BITS];
  logic [3:0] surv_mem [hdr_codec_pkg::ENC_BITS];

  wire logic rx_seq = rx_scr_q[6] ^ rx_scr_q[3];
  wire logic [9:0] rx_k = 10'(rx_col_q) * hdr_codec_pkg::IL_DEPTH + 10'(rx_row_q);
  wire logic rx_row_end = rx_col_q == ((rx_row_q < hdr_codec_pkg::IL_LONG_ROWS) ?
                          hdr_codec_pkg::IL_LONG_LAST_COL : hdr_codec_pkg::IL_SHORT_LAST_COL);
  wire logic rx_last = rx_row_end && (rx_row_q == hdr_codec_pkg::IL_LAST_ROW);
  wire logic [1:0] rx_pair = {rx_mem[{rx_t_q, 1'b1}], rx_mem[{rx_t_q, 1'b0}]};
  wire logic [3:0] tb_dec = surv_mem[rx_t_q];

  for (genvar ns = 0; ns < 4; ns++) begin : g_acs
    localparam logic [1:0] NS = 2'(ns);
    wire logic [1:0] e0 = conv_out(NS[1], {NS[0], 1'b0}) ^ rx_pair;
    wire logic [1:0] e1 = conv_out(NS[1], {NS[0], 1'b1}) ^ rx_pair;
    wire logic [10:0] m0 = pm_q[{NS[0], 1'b0}] + {10'h000, e0[0]} + {10'h000, e0[1]};
    wire logic [10:0] m1 = pm_q[{NS[0], 1'b1}] + {10'h000, e1[0]} + {10'h000, e1[1]};
    assign dec[ns] = (m1 < m0);
    assign pm_d[ns] = (m1 < m0) ? m1 : m0;
  end

  always_ff @(posedge ref_clk) begin
    if (rx_st_q == RX_FILL && rx_valid) begin
      rx_mem[rx_k] <= rx_bit ^ rx_seq;
    end
    if (rx_st_q == RX_ACS) begin
      surv_mem[rx_t_q] <= dec;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_st_q <= RX_IDLE;
      rx_scr_q <= hdr_codec_pkg::SCR_INIT;
      rx_row_q <= '0;
      rx_col_q <= '0;
      rx_t_q <= '0;
      tb_s_q <= '0;
      rx_crc_q <= hdr_codec_pkg::CRC_INIT;
      rx_hdr_q <= '0;
      rx_out_q <= '0;
      rx_done_q <= 1'b0;
      rx_ok_q <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        pm_q[i] <= '0;
      end
    end else begin
      rx_done_q <= 1'b0;
      if (rx_start) begin
        rx_scr_q <= hdr_codec_pkg::SCR_INIT;
        rx_row_q <= '0;
        rx_col_q <= '0;
        rx_st_q <= RX_FILL;
      end else begin
        unique case (rx_st_q)
          RX_IDLE: begin
          end
          RX_FILL: begin
            if (rx_valid) begin
              // arrivals fill rows, stored in column order
              rx_scr_q <= {rx_scr_q[5:0], rx_seq};
              rx_col_q <= rx_row_end ? 5'h00 : rx_col_q + 5'h01;
              rx_row_q <= rx_row_end ? rx_row_q + 5'h01 : rx_row_q;
              if (rx_last) begin
                rx_t_q <= '0;
                pm_q[0] <= '0;
                pm_q[1] <= hdr_codec_pkg::PM_BAD;
                pm_q[2] <= hdr_codec_pkg::PM_BAD;
                pm_q[3] <= hdr_codec_pkg::PM_BAD;
                rx_st_q <= RX_ACS;
              end
            end
          end
          RX_ACS: begin
            for (int i = 0; i < 4; i++) begin
              pm_q[i] <= pm_d[i];
            end
            rx_t_q <= rx_t_q + 9'h001;
            if (rx_t_q == 9'(hdr_codec_pkg::ENC_BITS - 1)) begin
              // traceback begins at the last trellis step, not one past it
              rx_t_q <= 9'(hdr_codec_pkg::ENC_BITS - 1);
              tb_s_q <= '0;
              rx_st_q <= RX_TB;
            end
          end
          RX_TB: begin
            // flush bits leave the trellis in state zero
            if (rx_t_q < 9'(hdr_codec_pkg::PROT_BITS)) begin
              rx_hdr_q[rx_t_q] <= tb_s_q[1];
            end
            tb_s_q <= {tb_s_q[0], tb_dec[tb_s_q]};
            rx_t_q <= rx_t_q - 9'h001;
            if (rx_t_q == 9'h000) begin
              rx_t_q <= '0;
              rx_crc_q <= hdr_codec_pkg::CRC_INIT;
              rx_st_q <= RX_CHK;
            end
          end
          RX_CHK: begin
            if (rx_t_q == 9'(hdr_codec_pkg::HDR_BITS)) begin
              rx_ok_q <= (~rx_crc_q == rx_hdr_q[327:312]);
              rx_done_q <= 1'b1;
              rx_out_q <= rx_hdr_q;
              rx_st_q <= RX_IDLE;
            end else begin
              rx_crc_q <= crc_step(rx_crc_q, rx_hdr_q[rx_t_q]);
              rx_t_q <= rx_t_q + 9'h001;
            end
          end
          default: rx_st_q <= RX_IDLE;
        endcase
      end
    end
  end

  assign rx_done = rx_done_q;
  assign rx_crc_ok = rx_ok_q;
  // published at done, so a half-finished traceback never shows
  assign rx_header = rx_out_q;
  // identity from the first own field only
  assign rx_station_id = rx_out_q[hdr_codec_pkg::OWN1_POS+:64];

endmodule // radio_header_fec_codec
`default_nettype wire

/* testbench/radio_header_fec_codec_assertions.sv */
// port checker for the radio header codec
`timescale 1ns/1ps
`default_nettype none
module codec_port_checker #(
  parameter int BIT_DIV = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // transmit
  input wire logic tx_start,
  input wire logic tx_busy,
  input wire logic tx_bit_valid,
  input wire logic pay_take,
  input wire logic pay_end,
  // receive
  input wire logic rx_start,
  input wire logic rx_valid,
  input wire logic rx_done,
  input wire logic rx_crc_ok,
  input wire logic [327:0] rx_header,
  input wire logic [63:0] rx_station_id
);
  logic [9:0] rx_cnt_q;
  logic [9:0] rx_cnt_d;
  logic [15:0] gap_q;
  logic [15:0] gap_d;
  logic end_taken;
  logic launch;
  assign end_taken = pay_take & pay_end;
  assign launch = tx_start & ~tx_busy;
  // bits taken since receive start, stops at a full header
  assign rx_cnt_d = rx_start ? 10'h000 :
    (rx_valid && rx_cnt_q != 10'h294) ? rx_cnt_q + 10'h001 : rx_cnt_q;
  // saturated value means no bit sent yet, so the first gap is not judged
  assign gap_d = launch ? 16'hFFFF : tx_bit_valid ? 16'h0000 :
    (gap_q == 16'hFFFF) ? gap_q : gap_q + 16'h0001;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_cnt_q <= 10'h000;
      gap_q <= 16'hFFFF;
    end else begin
      rx_cnt_q <= rx_cnt_d;
      gap_q <= gap_d;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence busy_two;
    tx_busy ##1 tx_busy;
  endsequence
  sequence take_then_send;
    tx_busy ##1 tx_bit_valid;
  endsequence
  start_busy_a: assert property (launch |=> busy_two)
    else $error("start not followed by busy");
  bit_gap_a: assert property (tx_bit_valid && gap_q != 16'hFFFF |-> gap_q == BIT_DIV - 1)
    else $error("bit spacing wrong");
  take_send_a: assert property (pay_take |-> take_then_send)
    else $error("payload bit not sent");
  end_release_a: assert property (end_taken |=> !tx_busy)
    else $error("busy kept after last bit");
  busy_fall_a: assert property ($fell(tx_busy) && $past(rst_n) |-> $past(end_taken))
    else $error("busy fell early");
  done_pulse_a: assert property (rx_done |=> !rx_done)
    else $error("done longer than one cycle");
  done_count_a: assert property (rx_done |-> rx_cnt_q == 10'h294)
    else $error("done before full header");
  decode_bound_a: assert property (rx_valid && !rx_start && rx_cnt_q == 10'h293 |-> ##[1:1000] rx_done)
    else $error("decode too slow");
  result_hold_a: assert property (!rx_done && $past(rst_n) |-> $stable(rx_header) && $stable(rx_crc_ok))
    else $error("result changed without done");
  id_match_a: assert property (rx_done |-> rx_station_id == rx_header[279:216])
    else $error("station id differs");
endmodule // codec_port_checker
bind radio_header_fec_codec codec_port_checker #(.BIT_DIV(BIT_DIV)) chk_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .tx_start(tx_start), .tx_busy(tx_busy),
  .tx_bit_valid(tx_bit_valid), .pay_take(pay_take), .pay_end(pay_end), .rx_start(rx_start),
  .rx_valid(rx_valid), .rx_done(rx_done), .rx_crc_ok(rx_crc_ok), .rx_header(rx_header),
  .rx_station_id(rx_station_id));
`default_nettype wire

/* testbench/modem_model.sv */
// radio modem model: records the sent stream, feeds payload, replays into the receiver
`timescale 1ns/1ps
`default_nettype none
module modem_model (
  // clock
  input wire logic ref_clk,
  // codec transmit side
  input wire logic tx_bit,
  input wire logic tx_bit_valid,
  input wire logic pay_take,
  output logic pay_bit,
  output logic pay_scramble,
  output logic pay_end,
  // codec receive side
  output logic rx_start,
  output logic rx_valid,
  output logic rx_bit
);
  logic cap [0:1023];
  int cap_n = 0;
  int pay_idx = 0;
  logic [15:0] pay_pat = 16'hA5C3;
  logic [15:0] pay_msk = 16'h0000;
  initial begin
    rx_start = 1'b0;
    rx_valid = 1'b0;
    rx_bit = 1'b0;
  end
  // mask bit 1 is a data frame bit, 0 a sync or terminator bit
  assign pay_bit = pay_pat[pay_idx[3:0]];
  assign pay_scramble = pay_msk[pay_idx[3:0]];
  assign pay_end = (pay_idx == 15);
  always @(posedge ref_clk) begin
    if (tx_bit_valid && cap_n < 1024) begin
      cap[cap_n] <= tx_bit;
      cap_n <= cap_n + 1;
    end
    if (pay_take) begin
      pay_idx <= pay_idx + 1;
    end
  end
  task automatic clear();
    cap_n = 0;
    pay_idx = 0;
  endtask
  // once released the line shows the inverse of its last bit, not a stale copy
  task automatic send_rx(input int f1, input int f2, input logic inv);
    @(posedge ref_clk);
    #2;
    rx_start = 1'b1;
    @(posedge ref_clk);
    #2;
    rx_start = 1'b0;
    for (int i = 0; i < 660; i++) begin
      rx_valid = 1'b1;
      rx_bit = cap[i] ^ inv ^ (i == f1) ^ (i == f2);
      @(posedge ref_clk);
      #2;
    end
    rx_valid = 1'b0;
    rx_bit = ~rx_bit;
  endtask
endmodule // modem_model
`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench for the radio header codec
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic tx_start = 1'b0;
  hdr_codec_pkg::hdr_req_s tx_req = '0;
  logic tx_busy, tx_bit, tx_bit_valid, pay_take, pay_bit, pay_scramble, pay_end;
  logic rx_start, rx_valid, rx_bit, rx_done, rx_crc_ok;
  logic [327:0] rx_header;
  logic [63:0] rx_station_id;
  logic exp_s [0:1023];
  int exp_n;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #25 ref_clk = ~ref_clk;
  // short bit period keeps the run brief
  radio_header_fec_codec #(.BIT_DIV(4)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .tx_start(tx_start), .tx_req(tx_req), .tx_busy(tx_busy), .tx_bit(tx_bit),
    .tx_bit_valid(tx_bit_valid), .pay_take(pay_take), .pay_bit(pay_bit),
    .pay_scramble(pay_scramble), .pay_end(pay_end), .rx_start(rx_start), .rx_valid(rx_valid),
    .rx_bit(rx_bit), .rx_done(rx_done), .rx_crc_ok(rx_crc_ok), .rx_header(rx_header),
    .rx_station_id(rx_station_id));
  modem_model modem (.ref_clk(ref_clk), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
    .pay_take(pay_take), .pay_bit(pay_bit), .pay_scramble(pay_scramble), .pay_end(pay_end),
    .rx_start(rx_start), .rx_valid(rx_valid), .rx_bit(rx_bit));
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      error_cnt++;
      $display("mismatch at %0t: run too long", $time);
      stop_test();
    end
  end
  task automatic chk_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic chk_vec(input logic [327:0] got, input logic [327:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [63:0] field(input hdr_codec_pkg::call_s c, input logic [7:0] last);
    logic [63:0] f;
    f[63:56] = last;
    for (int i = 0; i < 7; i++) begin
      f[8*i+:8] = (i < 6 && i < c.len) ? c.chars[8*i+:8] : hdr_codec_pkg::SPACE_CHAR;
    end
    return f;
  endfunction
  function automatic logic [7:0] radio(input logic [2:0] r);
    return (r == 3'h0) ? hdr_codec_pkg::SPACE_CHAR :
      (r > 3'h6) ? hdr_codec_pkg::CHAR_F : hdr_codec_pkg::CHAR_A + 8'(r) - 8'h01;
  endfunction
  function automatic logic [327:0] compose(input hdr_codec_pkg::hdr_req_s r);
    logic [327:0] h;
    logic [15:0] crc;
    logic [63:0] rp;
    h[23:0] = r.flags;
    h[87:24] = r.zone_to_zone ? field(r.gw_rptr, hdr_codec_pkg::CHAR_G) :
      field(r.comp_rptr, hdr_codec_pkg::CHAR_A + 8'(r.dest_site));
    h[151:88] = field(r.own_rptr, hdr_codec_pkg::CHAR_A + 8'(r.dep_site));
    rp = field(r.comp_rptr, hdr_codec_pkg::SPACE_CHAR);
    case (r.comp_mode)
      hdr_codec_pkg::CM_CQ: h[215:152] = {16'h2020, hdr_codec_pkg::GENERAL_CALL};
      hdr_codec_pkg::CM_CQ_ZONE: h[215:152] = {hdr_codec_pkg::CHAR_A + 8'(r.dest_site), rp[47:0],
        hdr_codec_pkg::SLASH_CHAR};
      hdr_codec_pkg::CM_SERVER: h[215:152] = field(r.comp_rptr, hdr_codec_pkg::CHAR_S);
      default: h[215:152] = field(r.comp_call, radio(r.comp_radio));
    endcase
    h[279:216] = field(r.own_call, radio(r.own_radio));
    for (int i = 0; i < 4; i++) begin
      h[280+8*i+:8] = (i < r.own2_len) ? r.own2[8*i+:8] : hdr_codec_pkg::SPACE_CHAR;
    end
    crc = hdr_codec_pkg::CRC_INIT;
    for (int i = 0; i < 312; i++) begin
      crc = (crc >> 1) ^ ((crc[0] ^ h[i]) ? hdr_codec_pkg::CRC_POLY_REFL : 16'h0000);
    end
    h[327:312] = ~crc;
    return h;
  endfunction
  function automatic void build(input logic [327:0] h, input logic [15:0] msk);
    logic [659:0] cw;
    logic [6:0] s;
    logic s1, s2, u, q;
    s1 = 1'b0;
    s2 = 1'b0;
    s = hdr_codec_pkg::SCR_INIT;
    exp_n = 0;
    for (int t = 0; t < 330; t++) begin
      u = (t < 328) ? h[t] : 1'b0;
      cw[2*t] = u ^ s1 ^ s2;
      cw[2*t+1] = u ^ s2;
      s2 = s1;
      s1 = u;
    end
    for (int row = 0; row < 24; row++) begin
      for (int col = 0; col < 28; col++) begin
        if (col * 24 + row < 660) begin
          q = s[6] ^ s[3];
          s = {s[5:0], q};
          exp_s[exp_n] = cw[col * 24 + row] ^ q;
          exp_n++;
        end
      end
    end
    // sync bits go out clear and leave the scrambler where it was
    for (int i = 0; i < 16; i++) begin
      q = msk[i] & (s[6] ^ s[3]);
      if (msk[i]) s = {s[5:0], q};
      exp_s[exp_n] = modem.pay_pat[i] ^ q;
      exp_n++;
    end
  endfunction
  task automatic send_pkt(input hdr_codec_pkg::hdr_req_s r, input logic [15:0] msk,
      input logic poke, input logic full);
    int n;
    modem.clear();
    modem.pay_msk = msk;
    tx_req = r;
    tx_start = 1'b1;
    @(posedge ref_clk);
    #2;
    tx_start = 1'b0;
    chk_bit(tx_busy, 1'b1, "busy");
    n = 0;
    while (tx_busy === 1'b1 && n < 9000) begin
      tx_start = poke && n == 50;
      tx_req = (poke && n == 50) ? hdr_codec_pkg::hdr_req_s'(~r) : r;
      @(posedge ref_clk);
      #2;
      n++;
    end
    // the last payload bit is still in flight for one cycle
    @(posedge ref_clk);
    #2;
    chk_bit(tx_busy, 1'b0, "busy end");
    if (full) begin
      build(compose(r), msk);
      chk_vec(328'(modem.cap_n), 328'(exp_n), "bit count");
      for (int i = 0; i < exp_n; i++) begin
        chk_bit(modem.cap[i], exp_s[i], "stream");
      end
    end
  endtask
  task automatic rx_check(input logic [327:0] h, input logic [327:0] m, input int f,
      input logic inv, input logic ok);
    int n;
    modem.send_rx(f, f + 331, inv);
    n = 0;
    while (rx_done !== 1'b1 && n < 1500) begin
      @(posedge ref_clk);
      #2;
      n++;
    end
    chk_bit(rx_done, 1'b1, "decode done");
    chk_bit(rx_crc_ok, ok, "checksum flag");
    if (ok) begin
      chk_vec(rx_header & m, h & m, "header");
      chk_vec(328'(rx_station_id), 328'(h[279:216]), "station id");
    end
  endtask
  task automatic test_station();
    hdr_codec_pkg::hdr_req_s r;
    r = '0;
    r.flags = 24'h000041;
    r.own_rptr = {48'h313141574141, 3'h3};
    r.comp_rptr = {48'h323241574242, 3'h5};
    r.comp_call = {48'h33334B4E4343, 3'h4};
    r.own_call = {48'h34344B4B4444, 3'h6};
    r.own2 = 32'h0031444A;
    r.own2_len = 3'h3;
    r.dep_site = 2'h2;
    r.own_radio = 3'h6;
    // mixed payload kinds and a refused restart midway
    send_pkt(r, 16'h0FF0, 1'b1, 1'b1);
    // two line errors must be corrected
    rx_check(compose(r), '1, 7, 1'b0, 1'b1);
    $display("station test done");
  endtask
  task automatic test_gateway_cq();
    hdr_codec_pkg::hdr_req_s r;
    r = '0;
    r.flags = 24'h03FF07;
    r.zone_to_zone = 1'b1;
    r.gw_rptr = {48'h353541574545, 3'h6};
    r.own_rptr = {48'h363641574646, 3'h6};
    r.dest_site = 2'h3;
    r.dep_site = 2'h3;
    r.comp_mode = hdr_codec_pkg::CM_CQ;
    r.own_radio = 3'h7;
    r.own2 = 32'h3243424A;
    r.own2_len = 3'h4;
    send_pkt(r, 16'hFFFF, 1'b0, 1'b1);
    rx_check(compose(r), '1, 2000, 1'b0, 1'b1);
    $display("gateway test done");
  endtask
  task automatic test_remote_modes();
    hdr_codec_pkg::hdr_req_s r;
    r = '0;
    r.comp_rptr = {48'h373741574747, 3'h6};
    r.own_call = {48'h38384B4B4848, 3'h5};
    r.dest_site = 2'h1;
    for (int m = 2; m < 4; m++) begin
      r.comp_mode = hdr_codec_pkg::comp_mode_e'(m);
      send_pkt(r, 16'h0000, 1'b0, 1'b0);
      rx_check(compose(r), '1, 2000, 1'b0, 1'b1);
      if (m == 2) begin
        chk_vec(328'(rx_header[159:152]), 328'(hdr_codec_pkg::SLASH_CHAR), "slash");
      end else begin
        chk_vec(328'(rx_header[215:208]), 328'(hdr_codec_pkg::CHAR_S), "server");
      end
    end
    $display("remote modes test done");
  endtask
  task automatic test_bad_rx();
    rx_check('0, '0, 2000, 1'b1, 1'b0);
    $display("bad receive test done");
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    #2;
    rst_n = 1'b1;
    test_station();
    test_gateway_cq();
    test_remote_modes();
    test_bad_rx();
    stop_test();
  end
endmodule // testbench
`default_nettype wire
